// ===== hdl/fodc_top.sv
// Fan drive control: register slave, cruise sequencing and PWM/DAC outputs
`timescale 1ns/100ps
module fodc_top #(
  parameter int UNIT_PWM_CYCLES = fodc_pkg::UNIT_PWM_CYC,
  parameter int UNIT_DC_CYCLES = fodc_pkg::UNIT_DC_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [9:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  output logic [1:0] avsResponse,
  output logic system_fan_drive,
  output logic processor_fan_drive,
  output logic [3:0] systemFanDac,
  output logic [3:0] processorFanDac,
  output logic systemFanPwmMode,
  output logic processorFanPwmMode,
  output logic auxiliaryFanPwmMode
);
  // Refuse unit counts the shared unit counter cannot serve: the DC unit must be
  // a whole number of PWM units, or the PWM ticks fall unevenly
  if (UNIT_PWM_CYCLES < 1 || UNIT_DC_CYCLES < UNIT_PWM_CYCLES ||
      (UNIT_DC_CYCLES % UNIT_PWM_CYCLES) != 0) begin
    $error("Stop time unit counts must be positive, DC a multiple of PWM");
  end

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  logic [7:0] sysClk_r, cpuClk_r, mode_r;
  logic [7:0] sysStop_r, cpuStop_r, sysStart_r, cpuStart_r;
  logic [7:0] sysStime_r, cpuStime_r, keep_r, thermal_r, drvType_r;
  logic [7:0] sysDrive_r, cpuDrive_r;
  logic [1:0] sysPh_r, cpuPh_r;
  logic [7:0] sysTcnt_r, cpuTcnt_r;
  logic [31:0] unitCnt_r;
  logic ack_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic [1:0] resp_r;

  // Bus decode
  // Only a write on byte lane 0 of a word-aligned address reaches a register
  logic [7:0] idx;
  logic req;
  logic wrEn;
  logic hit;
  logic [7:0] rdMux;
  logic [7:0] wd;
  assign idx = avsAddress[9:2];
  assign req = (avsRead || avsWrite) && !ack_r;
  assign wrEn = req && avsWrite && avsByteenable[0] && (avsAddress[1:0] == 2'b00);
  assign wd = avsWritedata[7:0];

  // Cruise phases: zero, stop-value hold, running
  typedef enum logic [1:0] {
    FODC_OFF = 2'b00,
    FODC_START = 2'b01,
    FODC_RUN = 2'b11,
    FODC_STOP = 2'b10
  } fodc_cruise_e;

  // Read mux
  // Reserved bits of masked registers read back as zero
  always_comb begin
    hit = 1'b1;
    case (idx)
      fodc_pkg::IDX_SYS_CLK: rdMux = sysClk_r;
      fodc_pkg::IDX_SYS_VAL: rdMux = sysDrive_r;
      fodc_pkg::IDX_CPU_CLK: rdMux = cpuClk_r;
      fodc_pkg::IDX_CPU_VAL: rdMux = cpuDrive_r;
      fodc_pkg::IDX_MODE: rdMux = mode_r & 8'h3C;
      fodc_pkg::IDX_SYS_STOP: rdMux = sysStop_r;
      fodc_pkg::IDX_CPU_STOP: rdMux = cpuStop_r;
      fodc_pkg::IDX_SYS_START: rdMux = sysStart_r;
      fodc_pkg::IDX_CPU_START: rdMux = cpuStart_r;
      fodc_pkg::IDX_SYS_STIME: rdMux = sysStime_r;
      fodc_pkg::IDX_CPU_STIME: rdMux = cpuStime_r;
      fodc_pkg::IDX_MINKEEP: rdMux = keep_r & 8'h30;
      fodc_pkg::IDX_THERMAL: rdMux = thermal_r & 8'h03;
      fodc_pkg::IDX_STATUS: rdMux = {4'h0, cpuPh_r, sysPh_r};
      fodc_pkg::IDX_DRV_TYPE: rdMux = drvType_r & 8'h70;
      default: begin
        rdMux = 8'h00;
        hit = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Avalon slave: one wait cycle, answer on the second
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_r <= 1'b0;
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
      resp_r <= fodc_pkg::AV_OKAY;
    end else begin
      ack_r <= req;
      wait_r <= !req;
      if (req) begin
        rdata_r <= avsRead ? {24'h00_0000, rdMux} : 32'h0000_0000;
        resp_r <= hit ? fodc_pkg::AV_OKAY : fodc_pkg::AV_DECERR;
      end
    end
  end
  // Waitrequest has its own flop, always the inverse of ack
  assign avsWaitrequest = wait_r;
  assign avsReaddata = rdata_r;
  assign avsResponse = resp_r;

  // Configuration writes
  // Writes land at the taking edge; the master holds the request through the answer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sysClk_r <= fodc_pkg::RST_CLK;
      cpuClk_r <= fodc_pkg::RST_CLK;
      mode_r <= fodc_pkg::RST_MODE;
      sysStop_r <= fodc_pkg::RST_STOP;
      cpuStop_r <= fodc_pkg::RST_STOP;
      sysStart_r <= fodc_pkg::RST_START;
      cpuStart_r <= fodc_pkg::RST_START;
      sysStime_r <= fodc_pkg::RST_STIME;
      cpuStime_r <= fodc_pkg::RST_STIME;
      keep_r <= 8'h00;
      thermal_r <= 8'h00;
      drvType_r <= fodc_pkg::RST_DRV_TYPE;
    end else if (wrEn) begin
      case (idx)
        fodc_pkg::IDX_SYS_CLK: sysClk_r <= wd;
        fodc_pkg::IDX_CPU_CLK: cpuClk_r <= wd;
        fodc_pkg::IDX_MODE: mode_r <= wd;
        fodc_pkg::IDX_SYS_STOP: sysStop_r <= wd;
        fodc_pkg::IDX_CPU_STOP: cpuStop_r <= wd;
        fodc_pkg::IDX_SYS_START: sysStart_r <= wd;
        fodc_pkg::IDX_CPU_START: cpuStart_r <= wd;
        fodc_pkg::IDX_SYS_STIME: sysStime_r <= wd;
        fodc_pkg::IDX_CPU_STIME: cpuStime_r <= wd;
        fodc_pkg::IDX_MINKEEP: keep_r <= wd;
        fodc_pkg::IDX_THERMAL: thermal_r <= wd;
        fodc_pkg::IDX_DRV_TYPE: drvType_r <= wd;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Stop-time unit tick: 0.1 s when PWM, 1.6 s when DC (per channel)
  // ------------------------------------------------------------
  // The first unit of a stop hold may be partial: the hold lasts n to n+1 units
  logic tickPwm, tickDc;
  assign tickPwm = (unitCnt_r % 32'(UNIT_PWM_CYCLES)) == 32'(UNIT_PWM_CYCLES - 1);
  assign tickDc = unitCnt_r == 32'(UNIT_DC_CYCLES - 1);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      unitCnt_r <= 32'h0000_0000;
    end else begin
      unitCnt_r <= tickDc ? 32'h0000_0000 : 32'(unitCnt_r + 32'h1);
    end
  end

  // Next value of one channel's drive and cruise phase
  // Fan speed cruise and the reserved code run as manual; the speed loop sits outside
  function automatic logic [17:0] cruise_step(
    input logic [1:0] mode, input logic [7:0] drive, input logic [1:0] ph,
    input logic [7:0] tcnt, input logic wrVal, input logic [7:0] wdat,
    input logic demand, input logic keep, input logic [7:0] stopV,
    input logic [7:0] startV, input logic [7:0] stime, input logic tick);
    logic [7:0] d;
    logic [1:0] p;
    logic [7:0] t;
    d = drive;
    p = ph;
    t = tcnt;
    // only thermal cruise sequences the value
    if (mode == fodc_pkg::FODC_THERMAL) begin
      case (p)
        FODC_RUN: begin
          if (wrVal) d = wdat;
          if (!demand) begin
            d = stopV;
            t = 8'h00;
            p = FODC_STOP;
          end
        end
        FODC_STOP: begin
          if (demand) begin
            p = FODC_RUN;
          end else if (!keep && tick) begin
            if (t >= stime) begin
              d = 8'h00;
              p = FODC_OFF;
            end else begin
              t = 8'(t + 8'h01);
            end
          end
        end
        FODC_OFF: begin
          // start from zero to start-up value
          if (demand) begin
            d = startV;
            p = FODC_RUN;
          end else if (keep) begin
            d = stopV;
            p = FODC_STOP;
          end
        end
        default: p = FODC_RUN;
      endcase
    end else begin
      p = FODC_RUN;
      if (wrVal) d = wdat;
    end
    return {d, p, t};
  endfunction

  // Per-channel decode: value writes, drive types and stop-time tick
  logic sysWrVal, cpuWrVal, sysPwm, cpuPwm, sysTick, cpuTick;
  assign sysWrVal = wrEn && (idx == fodc_pkg::IDX_SYS_VAL);
  assign cpuWrVal = wrEn && (idx == fodc_pkg::IDX_CPU_VAL);
  assign sysPwm = drvType_r[fodc_pkg::SYS_TYPE_BIT];
  assign cpuPwm = drvType_r[fodc_pkg::CPU_TYPE_BIT];
  assign sysTick = sysPwm ? tickPwm : tickDc;
  assign cpuTick = cpuPwm ? tickPwm : tickDc;

  logic [17:0] sysNxt, cpuNxt;
  assign sysNxt = cruise_step(mode_r[fodc_pkg::SYS_MODE_LSB +: 2], sysDrive_r, sysPh_r, sysTcnt_r,
    sysWrVal, wd, thermal_r[fodc_pkg::SYS_DEMAND_BIT],
    keep_r[fodc_pkg::SYS_KEEP_BIT], sysStop_r, sysStart_r, sysStime_r,
    sysTick);
  assign cpuNxt = cruise_step(mode_r[fodc_pkg::CPU_MODE_LSB +: 2], cpuDrive_r, cpuPh_r, cpuTcnt_r,
    cpuWrVal, wd, thermal_r[fodc_pkg::CPU_DEMAND_BIT],
    keep_r[fodc_pkg::CPU_KEEP_BIT], cpuStop_r, cpuStart_r, cpuStime_r,
    cpuTick);

  // Drive value and cruise state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sysDrive_r <= fodc_pkg::RST_VAL;
      cpuDrive_r <= fodc_pkg::RST_VAL;
      sysPh_r <= FODC_RUN;
      cpuPh_r <= FODC_RUN;
      sysTcnt_r <= 8'h00;
      cpuTcnt_r <= 8'h00;
    end else begin
      {sysDrive_r, sysPh_r, sysTcnt_r} <= sysNxt;
      {cpuDrive_r, cpuPh_r, cpuTcnt_r} <= cpuNxt;
    end
  end

  // ------------------------------------------------------------
  // PWM generators
  // ------------------------------------------------------------
  fodc_pwm_if sysPw ();
  fodc_pwm_if cpuPw ();
  assign sysPw.srcSel = sysClk_r[fodc_pkg::SRC_SEL_BIT];
  assign sysPw.divider = sysClk_r[6:0];
  assign sysPw.duty = sysDrive_r;
  assign cpuPw.srcSel = cpuClk_r[fodc_pkg::SRC_SEL_BIT];
  assign cpuPw.divider = cpuClk_r[6:0];
  assign cpuPw.duty = cpuDrive_r;
  fodc_pwm_gen uSysPwm (.clk(clk), .rstn(rstn), .pw(sysPw));
  fodc_pwm_gen uCpuPwm (.clk(clk), .rstn(rstn), .pw(cpuPw));

  // Output registers
  // A DC channel parks its waveform low, a PWM channel its DAC code at zero once out of reset (reset loads Fh)
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      system_fan_drive <= 1'b0;
      processor_fan_drive <= 1'b1;
      systemFanDac <= 4'hF;
      processorFanDac <= 4'hF;
      systemFanPwmMode <= 1'b0;
      processorFanPwmMode <= 1'b1;
      auxiliaryFanPwmMode <= 1'b0;
    end else begin
      system_fan_drive <= drvType_r[fodc_pkg::SYS_TYPE_BIT] & sysPw.pwmOut;
      processor_fan_drive <= drvType_r[fodc_pkg::CPU_TYPE_BIT] & cpuPw.pwmOut;
      systemFanDac <= drvType_r[fodc_pkg::SYS_TYPE_BIT] ? 4'h0 : sysDrive_r[7:4];
      processorFanDac <= drvType_r[fodc_pkg::CPU_TYPE_BIT] ? 4'h0 : cpuDrive_r[7:4];
      systemFanPwmMode <= drvType_r[fodc_pkg::SYS_TYPE_BIT];
      processorFanPwmMode <= drvType_r[fodc_pkg::CPU_TYPE_BIT];
      auxiliaryFanPwmMode <= drvType_r[fodc_pkg::AUX_TYPE_BIT];
    end
  end
endmodule

// ===== hdl/fodc_pkg.sv
// Package with register map, field positions, reset values and timing constants of the fan drive block
// Function
// - Drive type bits 4/5/6 select DC or PWM
// - Bit 7 picks 24 MHz or 180 kHz
// - Bits 6..0 divide the source by n
// - PWM rate is source over n over 256
// - Duty is value/255, FFh high, 00h low; the counter gives value/256 below FFh
// - DC mode drives value bits 7..4 to DAC
// - Output value registers reset to FFh
// - Frequency and value registers at fixed indices
// - Two-bit mode field: manual, thermal, speed cruise
// - Thermal cruise falls back to stop value
// - Thermal cruise start rises to start-up value
// - Stop time holds stop value before zero
// - Keep-minimum bit holds stop value instead
package fodc_pkg;
  // ------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_SYS_CLK = 8'h00;
  localparam logic [7:0] IDX_SYS_VAL = 8'h01;
  localparam logic [7:0] IDX_CPU_CLK = 8'h02;
  localparam logic [7:0] IDX_CPU_VAL = 8'h03;
  localparam logic [7:0] IDX_MODE = 8'h04;
  localparam logic [7:0] IDX_SYS_STOP = 8'h08;
  localparam logic [7:0] IDX_CPU_STOP = 8'h09;
  localparam logic [7:0] IDX_SYS_START = 8'h0A;
  localparam logic [7:0] IDX_CPU_START = 8'h0B;
  localparam logic [7:0] IDX_SYS_STIME = 8'h0C;
  localparam logic [7:0] IDX_CPU_STIME = 8'h0D;
  localparam logic [7:0] IDX_MINKEEP = 8'h12;
  localparam logic [7:0] IDX_THERMAL = 8'h20;
  localparam logic [7:0] IDX_STATUS = 8'h21;
  localparam logic [7:0] IDX_DRV_TYPE = 8'hF0;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int SRC_SEL_BIT = 7;
  localparam int SYS_TYPE_BIT = 4;
  localparam int CPU_TYPE_BIT = 5;
  localparam int AUX_TYPE_BIT = 6;
  localparam int SYS_MODE_LSB = 2;
  localparam int CPU_MODE_LSB = 4;
  localparam int SYS_KEEP_BIT = 5;
  localparam int CPU_KEEP_BIT = 4;
  localparam int SYS_DEMAND_BIT = 0;
  localparam int CPU_DEMAND_BIT = 1;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_CLK = 8'h01;
  localparam logic [7:0] RST_VAL = 8'hFF;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_STOP = 8'h01;
  localparam logic [7:0] RST_START = 8'h01;
  localparam logic [7:0] RST_STIME = 8'h3C;
  localparam logic [7:0] RST_DRV_TYPE = 8'h20;
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  // ------------------------------------------------------------
  // Modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    FODC_MANUAL = 2'b00,
    FODC_THERMAL = 2'b01,
    FODC_SPEED = 2'b10,
    FODC_RSVD = 2'b11
  } fodc_mode_e;
  // ------------------------------------------------------------
  // Timing: clock 40 MHz, sources 24 MHz and 180 kHz, stop time unit
  // ------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int SRC_FAST_HZ = 24_000_000;
  localparam int SRC_SLOW_HZ = 180_000;
  localparam int PHASE_W = 32;
  // Phase increments of a 32-bit accumulator, one wrap per source tick
  localparam logic [31:0] INC_FAST = 32'((64'(SRC_FAST_HZ) << 32) / 64'(CLK_HZ));
  localparam logic [31:0] INC_SLOW = 32'((64'(SRC_SLOW_HZ) << 32) / 64'(CLK_HZ));
  localparam int UNIT_PWM_MS = 100;
  localparam int UNIT_DC_MS = 1600;
  localparam int UNIT_PWM_CYC = CLK_HZ / 1000 * UNIT_PWM_MS;
  localparam int UNIT_DC_CYC = CLK_HZ / 1000 * UNIT_DC_MS;
  localparam logic [1:0] AV_OKAY = 2'b00;
  localparam logic [1:0] AV_DECERR = 2'b11;
endpackage

// ===== hdl/fodc_pwm_if.sv
// Interface carrying one channel's PWM settings and waveform
`timescale 1ns/100ps
interface fodc_pwm_if;
  logic srcSel;
  logic [6:0] divider;
  logic [7:0] duty;
  logic pwmOut;
  modport ctl (output srcSel, output divider, output duty, input pwmOut);
  modport gen (input srcSel, input divider, input duty, output pwmOut);
endinterface

// ===== hdl/fodc_pwm_gen.sv
// One PWM channel: source tick, prescaler and 8-bit duty counter
`timescale 1ns/100ps
module fodc_pwm_gen (
  input wire logic clk,
  input wire logic rstn,
  fodc_pwm_if.gen pw
);
  logic [31:0] phase_r;
  logic [32:0] phaseSum;
  logic srcTick;
  logic [6:0] pre_r;
  logic [7:0] cnt_r;
  logic out_r;
  logic preDone;
  logic [6:0] divEff;

  // ------------------------------------------------------------
  // Source tick from a phase accumulator
  // ------------------------------------------------------------
  // source clock select
  assign phaseSum = {1'b0, phase_r} + {1'b0, pw.srcSel ? fodc_pkg::INC_SLOW : fodc_pkg::INC_FAST};
  assign srcTick = phaseSum[32];
  // Zero divider is illegal; treated as one to keep the counter alive
  assign divEff = (pw.divider == 7'h00) ? 7'h01 : pw.divider;
  assign preDone = srcTick && (pre_r >= 7'(divEff - 7'h01));

  // Accumulator and prescaler
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_r <= 32'h0000_0000;
      pre_r <= 7'h00;
    end else begin
      phase_r <= phaseSum[31:0];
      if (preDone) begin
        pre_r <= 7'h00;
      end else if (srcTick) begin
        pre_r <= 7'(pre_r + 7'h01);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 8'h00;
      out_r <= 1'b1;
    end else begin
      if (preDone) begin
        cnt_r <= 8'(cnt_r + 8'h01);
      end
      out_r <= (pw.duty == fodc_pkg::DUTY_FULL) || (cnt_r < pw.duty);
    end
  end
  assign pw.pwmOut = out_r;
endmodule

// ===== bench/fodc_top_asserts.sv
// Port checker for the fan drive block
`timescale 1ns/100ps
module fodc_top_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [9:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  input wire logic [31:0] avsReaddata,
  input wire logic avsWaitrequest,
  input wire logic [1:0] avsResponse,
  input wire logic system_fan_drive,
  input wire logic processor_fan_drive,
  input wire logic [3:0] systemFanDac,
  input wire logic [3:0] processorFanDac,
  input wire logic systemFanPwmMode,
  input wire logic processorFanPwmMode,
  input wire logic auxiliaryFanPwmMode
);
  // --
  // Shadow of accepted value and mode writes
  // --
  logic [7:0] sysVal_r;
  logic [7:0] cpuVal_r;
  logic [3:0] mode_r;
  wire wrTaken = avsWrite && avsWaitrequest && avsByteenable[0];
  wire sysMan = mode_r[1:0] == 2'h0;
  wire cpuMan = mode_r[3:2] == 2'h0;
  // Capture at the taking edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sysVal_r <= 8'hFF;
      cpuVal_r <= 8'hFF;
      mode_r <= 4'h0;
    end else if (wrTaken) begin
      if (avsAddress == 10'h004) sysVal_r <= avsWritedata[7:0];
      if (avsAddress == 10'h00C) cpuVal_r <= avsWritedata[7:0];
      if (avsAddress == 10'h010) mode_r <= avsWritedata[5:2];
    end
  end
  // --
  // Assertions
  // --
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence sTaken;
    (avsRead || avsWrite) && avsWaitrequest;
  endsequence
  sequence sTypeWr;
    wrTaken && avsAddress == 10'h3C0;
  endsequence
  a_wait_one: assert property (sTaken |=> !avsWaitrequest)
    else $error("no answer after one wait cycle");
  a_wait_once: assert property (!avsWaitrequest |=> avsWaitrequest)
    else $error("answer longer than one cycle");
  a_read_clean: assert property (avsRead && !avsWaitrequest |->
    avsReaddata[31:8] == 24'h00_0000 && (avsResponse == 2'h0 || avsReaddata[7:0] == 8'h00))
    else $error("bad read answer");
  a_type_copy: assert property (sTypeWr |-> ##3
    {auxiliaryFanPwmMode, processorFanPwmMode, systemFanPwmMode} == $past(avsWritedata[6:4], 3))
    else $error("drive type pins differ from write");
  a_dc_quiet: assert property (!systemFanPwmMode [*3] |-> !system_fan_drive)
    else $error("waveform in DC mode");
  // no DAC code in PWM mode
  a_pwm_nodac: assert property (processorFanPwmMode [*3] |-> processorFanDac == 4'h0)
    else $error("DAC code in PWM mode");
  a_full_high: assert property ((cpuMan && cpuVal_r == 8'hFF && processorFanPwmMode) [*4] |->
    processor_fan_drive) else $error("full duty not high");
  a_zero_low: assert property ((sysMan && sysVal_r == 8'h00 && systemFanPwmMode) [*4] |->
    !system_fan_drive) else $error("zero duty not low");
  a_sys_dac: assert property ((sysMan && !systemFanPwmMode && $stable(sysVal_r)) [*4] |->
    systemFanDac == sysVal_r[7:4]) else $error("system DAC code wrong");
  a_cpu_dac: assert property ((cpuMan && !processorFanPwmMode && $stable(cpuVal_r)) [*4] |->
    processorFanDac == cpuVal_r[7:4]) else $error("processor DAC code wrong");
endmodule
bind fodc_top fodc_top_asserts fodc_top_asserts_inst (.clk(clk), .rstn(rstn), .avsAddress(avsAddress),
  .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
  .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .avsResponse(avsResponse),
  .system_fan_drive(system_fan_drive), .processor_fan_drive(processor_fan_drive),
  .systemFanDac(systemFanDac), .processorFanDac(processorFanDac), .systemFanPwmMode(systemFanPwmMode),
  .processorFanPwmMode(processorFanPwmMode), .auxiliaryFanPwmMode(auxiliaryFanPwmMode));

// ===== bench/fodc_fan_model.sv
// Fan pre-driver model measuring the received waveform
`timescale 1ns/100ps
module fodc_fan_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic drive,
  output logic [15:0] periodLen,
  output logic [15:0] highLen
);
  logic drive_r;
  logic [15:0] runCnt_r;
  logic [15:0] highCnt_r;
  // Period and high time between rising edges
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      drive_r <= 1'h0;
      runCnt_r <= 16'h0000;
      highCnt_r <= 16'h0000;
      periodLen <= 16'h0000;
      highLen <= 16'h0000;
    end else begin
      drive_r <= drive;
      if (drive && !drive_r) begin
        periodLen <= runCnt_r;
        highLen <= highCnt_r;
        runCnt_r <= 16'h0001;
        highCnt_r <= 16'h0001;
      end else begin
        runCnt_r <= runCnt_r + 16'h0001;
        highCnt_r <= highCnt_r + {15'h0000, drive};
      end
    end
  end
endmodule

// ===== bench/tb_fodc_top.sv
// Self-checking bench for the fan drive block
`timescale 1ns/100ps
`define CHK(nm, e, s) begin samplesChecked++; if ((s) !== (e)) begin badCount++; \
  $display("Error %s expected %h seen %h", nm, e, s); end end
module tb_fodc_top;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic [9:0] avsAddress = 10'h000;
  logic avsRead = 1'h0;
  logic avsWrite = 1'h0;
  logic [31:0] avsWritedata = 32'h0000_0000;
  logic [3:0] avsByteenable = 4'h1;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  logic [1:0] avsResponse;
  logic sysDrive, cpuDrive;
  logic [3:0] sysDac, cpuDac;
  logic [2:0] pwmModes;
  logic [15:0] sysPer, sysHigh, cpuPer, cpuHigh;
  logic [9:0] noteQ[$];
  logic [9:0] note;
  logic [7:0] v, w;
  logic [7:0] idxTab[11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'hF0};
  logic [7:0] rstTab[11] = '{8'h01, 8'hFF, 8'h01, 8'hFF, 8'h00, 8'h01, 8'h01, 8'h01,
    fodc_pkg::RST_START, fodc_pkg::RST_STIME, fodc_pkg::RST_DRV_TYPE};
  int rises;
  int badCount = 0;
  int samplesChecked = 0;
  // Clock of 25 ns
  initial begin
    forever #12.5 clk = ~clk;
  end
  // Design with short stop time units, and one fan model per channel
  fodc_top #(.UNIT_PWM_CYCLES(10), .UNIT_DC_CYCLES(160)) fodc_top_inst (.clk(clk), .rstn(rstn),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
    .avsByteenable(avsByteenable), .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
    .avsResponse(avsResponse), .system_fan_drive(sysDrive), .processor_fan_drive(cpuDrive),
    .systemFanDac(sysDac), .processorFanDac(cpuDac), .systemFanPwmMode(pwmModes[0]),
    .processorFanPwmMode(pwmModes[1]), .auxiliaryFanPwmMode(pwmModes[2]));
  fodc_fan_model fanSys (.clk(clk), .rstn(rstn), .drive(sysDrive), .periodLen(sysPer), .highLen(sysHigh));
  fodc_fan_model fanCpu (.clk(clk), .rstn(rstn), .drive(cpuDrive), .periodLen(cpuPer), .highLen(cpuHigh));
  // Verdict and end of run
  task automatic endOfTest;
    if (badCount == 0 && samplesChecked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Measured length within three cycles
  function automatic logic near(input logic [15:0] a, input int e);
    return (int'(a) > e - 4) && (int'(a) < e + 4);
  endfunction
  // Bus transfer held until waitrequest is seen low
  task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] d, input logic [1:0] r);
    if (!we) noteQ.push_back({r, d});
    avsAddress <= {idx, 2'h0};
    avsWritedata <= {24'h00_0000, d};
    avsRead <= !we;
    avsWrite <= we;
    do @(posedge clk); while (avsWaitrequest !== 1'h0);
    avsRead <= 1'h0;
    avsWrite <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'h1, idx, d, fodc_pkg::AV_OKAY);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] r = fodc_pkg::AV_OKAY);
    xfer(1'h0, idx, e, r);
  endtask
  // Watchdog cuts a hung run short
  initial begin
    repeat (20000) @(posedge clk);
    badCount++;
    endOfTest;
  end
  // Compare each answered read with the oldest note
  always @(posedge clk) begin
    if (avsRead && avsWaitrequest === 1'h0) begin
      note = noteQ.pop_front();
      `CHK("readback", note, {avsResponse, avsReaddata[7:0]})
    end
  end
  // --
  // Test sequence
  // --
  initial begin
    void'($urandom(69));
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    `CHK("pwmModes", 3'h2, pwmModes)
    `CHK("sysDac", 4'hF, sysDac)
    for (int i = 0; i < 11; i++) rd(idxTab[i], rstTab[i]);
    wr(8'h40, 8'h33);
    rd(8'h40, 8'h00, fodc_pkg::AV_DECERR);
    avsByteenable <= 4'h0;
    wr(8'h08, 8'h22);
    avsByteenable <= 4'h1;
    rd(8'h08, 8'h01);
    for (int i = 0; i < 10; i++) begin
      v = (i == 4) ? 8'h00 : 8'($urandom) | 8'h01;
      wr(idxTab[i], v);
      rd(idxTab[i], v);
    end
    wr(8'hF0, 8'h00);
    repeat (4) begin
      v = 8'($urandom);
      w = 8'($urandom);
      wr(8'h01, v);
      wr(8'h03, w);
      repeat (4) @(posedge clk);
      `CHK("sysDac", v[7:4], sysDac)
      `CHK("cpuDac", w[7:4], cpuDac)
    end
    `CHK("pwmModes", 3'h0, pwmModes)
    wr(8'hF0, 8'h50);
    repeat (4) @(posedge clk);
    `CHK("pwmModes", 3'h5, pwmModes)
    wr(8'hF0, 8'h30);
    wr(8'h00, 8'h01);
    wr(8'h01, 8'h40);
    wr(8'h02, 8'h02);
    wr(8'h03, 8'hC0);
    repeat (3000) @(posedge clk);
    `CHK("sysPer", 1'h1, near(sysPer, 256 * 40 / 24))
    `CHK("sysHigh", 1'h1, near(sysHigh, 64 * 40 / 24))
    `CHK("cpuPer", 1'h1, near(cpuPer, 512 * 40 / 24))
    `CHK("cpuHigh", 1'h1, near(cpuHigh, 384 * 40 / 24))
    wr(8'h00, 8'h81);
    w[0] = sysDrive;
    rises = 0;
    repeat (3000) begin
      @(posedge clk);
      rises += int'(sysDrive && !w[0]);
      w[0] = sysDrive;
    end
    `CHK("slowRises", 1'h1, rises < 2)
    wr(8'h01, 8'h00);
    repeat (30) @(posedge clk);
    `CHK("sysDrive", 1'h0, sysDrive)
    // manual, speed cruise and reserved codes
    for (int m = 0; m < 4; m += 1 + int'(m == 0)) begin
      wr(8'h04, {2'h0, 2'(m), 2'(m), 2'h0});
      v = 8'($urandom);
      wr(8'h20, 8'h00);
      wr(8'h01, v);
      wr(8'h20, 8'h03);
      repeat (30) @(posedge clk);
      rd(8'h01, v);
    end
    wr(8'h08, 8'h30);
    wr(8'h0A, 8'h90);
    wr(8'h0C, 8'h02);
    wr(8'h12, 8'h00);
    wr(8'h04, 8'h04);
    wr(8'h20, 8'h00);
    rd(8'h01, 8'h30);
    repeat (40) @(posedge clk);
    rd(8'h01, 8'h00);
    wr(8'h20, 8'h01);
    rd(8'h01, 8'h90);
    wr(8'h12, 8'h20);
    wr(8'h20, 8'h00);
    repeat (60) @(posedge clk);
    rd(8'h01, 8'h30);
    // stop time counted in DC units
    wr(8'hF0, 8'h20);
    wr(8'h12, 8'h00);
    repeat (200) @(posedge clk);
    rd(8'h01, 8'h30);
    repeat (300) @(posedge clk);
    rd(8'h01, 8'h00);
    rstn <= 1'h0;
    repeat (3) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    rd(8'h04, 8'h00);
    rd(8'h01, 8'hFF);
    endOfTest;
  end
endmodule
